// File: logic/ims_master.v
// Notes on behaviour
// - the transfer-active flag is high while the bus is in use and its rise empties the tx fifo.
// - a missing slave acknowledge sets the no-ack flag and ends the transfer; only a zero write clears it.
// - the receive-pending flag sets while the rx fifo holds a byte and stays until written zero.
// - the transmit-empty flag sets when the tx fifo becomes empty and stays until written zero.
// - the two-bit level field reports the active fifo as 00 empty, 10 half full, 11 full.
// - a simultaneous write and read strobe sets the access-collision flag, cleared by a zero write.
// - a tx buffer write while the tx fifo is full sets the overflow flag, cleared by a zero write.
// - the lowest bit of the target address register chooses read or write on the slave.
// - during a read the master acknowledges each received byte except the last by itself.
// - after the receive count plus one bytes are read the master sends a not-acknowledge.
// - rewriting the target address during a transfer gives a repeated start, not a stop.
// - a target address write starts a transaction when the interface enable bit is set.
// - direction one reads into the rx buffer, direction zero writes from the tx buffer.
// - reception stops after the receive count plus one bytes, even when the rx fifo is full.
`timescale 1ns/1ps
`include "ims_regs.vh"

module ims_master (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  output reg [7:0] sfr_rdata_o,
  output reg irq_o,
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe_n_o,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_n_o
);

  // ==========================================================================
  // states and quarter-bit phases
  localparam ST_IDLE = 6'b000001;
  localparam ST_START = 6'b000010;
  localparam ST_BYTE = 6'b000100;
  localparam ST_ACK = 6'b001000;
  localparam ST_RSTART = 6'b010000;
  localparam ST_STOP = 6'b100000;
  localparam Q0 = 2'h0;
  localparam Q1 = 2'h1;
  localparam Q2 = 2'h2;
  localparam Q3 = 2'h3;
  localparam BIT_LAST = 3'h7;

  reg [5:0] state_r;
  reg [1:0] q_r;
  reg [2:0] bit_r;
  reg [7:0] shift_r;
  reg [7:0] mode_r;
  reg [7:0] taddr_r;
  reg busy_r, go_r, restart_r, is_addr_r, dir_r, ack_hi_r, last_r;
  reg [4:0] rx_cnt_r;
  reg noack_r, rxp_r, txe_r, acc_r, ovf_r;
  reg scl_lo_r, sda_lo_r;
  reg scl_m_r, scl_s_r, sda_m_r, sda_s_r;
  reg tx_empty_d_r;
  reg tx_flush, tx_pop, rx_push, set_noack;

  wire tick;
  wire tx_mode;
  wire stall;
  wire adv;
  wire [7:0] tx_head, rx_head;
  wire [2:0] tx_cnt, rx_cnt_f;
  wire tx_full, tx_empty, rx_full, rx_empty;
  wire wr_tx, rd_rx, wr_stat, wr_taddr;
  wire [1:0] lvl;

  // ==========================================================================
  // clearable flag update: set wins, a written one keeps the flag
  function upd;
    input cur;
    input set;
    input wr;
    input wbit;
    begin
      upd = set | (cur & ~(wr & ~wbit));
    end
  endfunction

  // level code for the fifo in use
  function [1:0] lvl_code;
    input [2:0] cnt;
    input full;
    begin
      if (full)
        lvl_code = `IMS_LVL_FULL;
      else if (cnt != 3'h0)
        lvl_code = `IMS_LVL_HALF;
      else
        lvl_code = `IMS_LVL_EMPTY;
    end
  endfunction

  // ==========================================================================
  // register port decode
  assign wr_tx = sfr_wr_i & (sfr_addr_i == `IMS_ADDR_TXBUF);
  assign rd_rx = sfr_rd_i & (sfr_addr_i == `IMS_ADDR_RXBUF);
  assign wr_stat = sfr_wr_i & (sfr_addr_i == `IMS_ADDR_STAT);
  assign wr_taddr = sfr_wr_i & (sfr_addr_i == `IMS_ADDR_TADDR);
  assign tx_mode = is_addr_r | ~dir_r;
  assign lvl = dir_r ? lvl_code(rx_cnt_f, rx_full) : lvl_code(tx_cnt, tx_full);
  // hold the high phase while a slave stretches the clock
  assign stall = (q_r == Q2) & ~scl_lo_r & ~scl_s_r;
  assign adv = tick & ~stall;

  // ==========================================================================
  // fifos and bit-rate tick
  ims_fifo #(.WIDTH(8), .DEPTH(`IMS_FIFO_DEPTH), .AW(2)) u_txf (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .flush_i(tx_flush),
    .push_i(wr_tx),
    .wdata_i(sfr_wdata_i),
    .pop_i(tx_pop),
    .head_o(tx_head),
    .count_o(tx_cnt),
    .full_o(tx_full),
    .empty_o(tx_empty)
  );

  ims_fifo #(.WIDTH(8), .DEPTH(`IMS_FIFO_DEPTH), .AW(2)) u_rxf (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .flush_i(1'b0),
    .push_i(rx_push),
    .wdata_i(shift_r),
    .pop_i(rd_rx),
    .head_o(rx_head),
    .count_o(rx_cnt_f),
    .full_o(rx_full),
    .empty_o(rx_empty)
  );

  ims_tick_gen u_tick (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .run_i(busy_r),
    .rate_i(mode_r[`IMS_MD_RATE_HI:`IMS_MD_RATE_LO]),
    .tick_o(tick)
  );

  // ==========================================================================
  // pin synchronisers
  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end
    else
    begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
    end
  end

  // ==========================================================================
  // fifo strobes from the sequencer
  always @*
  begin
    tx_flush = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    set_noack = 1'b0;
    if ((state_r == ST_IDLE) && go_r)
      tx_flush = 1'b1;
    if ((state_r == ST_ACK) && adv && (q_r == Q2) && !tx_mode)
      rx_push = 1'b1;
    if ((state_r == ST_ACK) && adv && (q_r == Q3))
    begin
      if (tx_mode && ack_hi_r)
      begin
        set_noack = 1'b1;
        tx_flush = 1'b1;
      end
      else if (!is_addr_r || !dir_r)
        tx_pop = tx_mode & ~tx_empty;
    end
  end

  // ==========================================================================
  // sequencer: start, bytes, acknowledge, repeated start, stop
  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r <= ST_IDLE;
      q_r <= Q0;
      bit_r <= 3'h0;
      shift_r <= `IMS_RST_BYTE;
      busy_r <= 1'b0;
      is_addr_r <= 1'b0;
      dir_r <= 1'b0;
      ack_hi_r <= 1'b0;
      last_r <= 1'b0;
      rx_cnt_r <= 5'h00;
      scl_lo_r <= 1'b0;
      sda_lo_r <= 1'b0;
    end
    else
    begin
      if (adv)
        q_r <= q_r + 1'b1;
      case (state_r)
        ST_IDLE:
        begin
          scl_lo_r <= 1'b0;
          sda_lo_r <= 1'b0;
          q_r <= Q0;
          if (go_r)
          begin
            busy_r <= 1'b1;
            state_r <= ST_START;
          end
        end
        ST_START, ST_RSTART:
        begin
          if (adv)
          begin
            case (q_r)
              Q0: sda_lo_r <= (state_r == ST_START);
              Q1: scl_lo_r <= 1'b0;
              Q2: sda_lo_r <= 1'b1;
              default:
              begin
                scl_lo_r <= 1'b1;
                shift_r <= taddr_r;
                dir_r <= taddr_r[`IMS_TA_DIR];
                is_addr_r <= 1'b1;
                bit_r <= 3'h0;
                rx_cnt_r <= 5'h00;
                state_r <= ST_BYTE;
              end
            endcase
          end
        end
        ST_BYTE:
        begin
          if (adv)
          begin
            case (q_r)
              Q0: sda_lo_r <= tx_mode & ~shift_r[7];
              Q1: scl_lo_r <= 1'b0;
              Q2: shift_r <= {shift_r[6:0], sda_s_r};
              default:
              begin
                scl_lo_r <= 1'b1;
                bit_r <= bit_r + 1'b1;
                if (bit_r == BIT_LAST)
                  state_r <= ST_ACK;
              end
            endcase
          end
        end
        ST_ACK:
        begin
          if (adv)
          begin
            case (q_r)
              Q0:
              begin
                last_r <= (rx_cnt_r == mode_r[`IMS_MD_RCT_HI:0]);
                // ack low for each received byte but the last, release for the final nack and for the slave ack on a send
                sda_lo_r <= ~tx_mode & (rx_cnt_r != mode_r[`IMS_MD_RCT_HI:0]);
              end
              Q1: scl_lo_r <= 1'b0;
              Q2:
              begin
                ack_hi_r <= sda_s_r;
                if (!tx_mode)
                  rx_cnt_r <= rx_cnt_r + 5'h01;
              end
              default:
              begin
                scl_lo_r <= 1'b1;
                bit_r <= 3'h0;
                if (tx_mode && ack_hi_r)
                  state_r <= ST_STOP;
                else if (is_addr_r && dir_r)
                begin
                  is_addr_r <= 1'b0;
                  state_r <= ST_BYTE;
                end
                else if (tx_mode && !tx_empty)
                begin
                  is_addr_r <= 1'b0;
                  shift_r <= tx_head;
                  state_r <= ST_BYTE;
                end
                else if (!tx_mode && !last_r)
                  state_r <= ST_BYTE;
                else if (restart_r)
                  state_r <= ST_RSTART;
                else
                  state_r <= ST_STOP;
              end
            endcase
          end
        end
        ST_STOP:
        begin
          if (adv)
          begin
            case (q_r)
              Q0: sda_lo_r <= 1'b1;
              Q1: scl_lo_r <= 1'b0;
              Q2: sda_lo_r <= 1'b0;
              default:
              begin
                busy_r <= 1'b0;
                state_r <= ST_IDLE;
              end
            endcase
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // mode, target address, start and restart requests
  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mode_r <= `IMS_RST_BYTE;
      taddr_r <= `IMS_RST_BYTE;
      go_r <= 1'b0;
      restart_r <= 1'b0;
    end
    else
    begin
      if (sfr_wr_i && (sfr_addr_i == `IMS_ADDR_MODE))
        mode_r <= sfr_wdata_i;
      if (wr_taddr)
        taddr_r <= sfr_wdata_i;
      if (wr_taddr && mode_r[`IMS_MD_EN] && !busy_r)
        go_r <= 1'b1;
      else if (state_r != ST_IDLE)
        go_r <= 1'b0;
      if (wr_taddr && mode_r[`IMS_MD_EN] && busy_r)
        restart_r <= 1'b1;
      else if (state_r == ST_RSTART || state_r == ST_IDLE)
        restart_r <= 1'b0;
    end
  end

  // ==========================================================================
  // sticky status flags
  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      noack_r <= 1'b0;
      rxp_r <= 1'b0;
      txe_r <= 1'b0;
      acc_r <= 1'b0;
      ovf_r <= 1'b0;
      tx_empty_d_r <= 1'b1;
    end
    else
    begin
      tx_empty_d_r <= tx_empty;
      noack_r <= upd(noack_r, set_noack, wr_stat, sfr_wdata_i[`IMS_ST_NOACK]);
      rxp_r <= upd(rxp_r, ~rx_empty, wr_stat, sfr_wdata_i[`IMS_ST_RXP]);
      txe_r <= upd(txe_r, tx_empty & ~tx_empty_d_r, wr_stat,
                   sfr_wdata_i[`IMS_ST_TXE]);
      acc_r <= upd(acc_r, sfr_wr_i & sfr_rd_i, wr_stat, sfr_wdata_i[`IMS_ST_ACC]);
      ovf_r <= upd(ovf_r, wr_tx & tx_full, wr_stat, sfr_wdata_i[`IMS_ST_OVF]);
    end
  end

  // ==========================================================================
  // registered outputs: read data, interrupt, open-drain pins
  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sfr_rdata_o <= `IMS_RST_BYTE;
      irq_o <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n_o <= 1'b1;
      sda_oe_n_o <= 1'b1;
    end
    else
    begin
      irq_o <= noack_r | rxp_r | txe_r | acc_r | ovf_r;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n_o <= ~scl_lo_r;
      sda_oe_n_o <= ~sda_lo_r;
      if (sfr_rd_i)
      begin
        case (sfr_addr_i)
          `IMS_ADDR_RXBUF: sfr_rdata_o <= rx_head;
          `IMS_ADDR_MODE: sfr_rdata_o <= mode_r;
          `IMS_ADDR_TADDR: sfr_rdata_o <= taddr_r;
          `IMS_ADDR_STAT: sfr_rdata_o <= {busy_r, noack_r, rxp_r, txe_r, lvl, acc_r, ovf_r};
          default: sfr_rdata_o <= `IMS_RST_BYTE;
        endcase
      end
    end
  end

endmodule // ims_master

// File: logic/ims_regs.vh
`ifndef IMS_REGS_VH
`define IMS_REGS_VH

// ==========================================================================
// register addresses on the special function register port
`define IMS_ADDR_TXBUF 8'h9a
`define IMS_ADDR_RXBUF 8'h9b
`define IMS_ADDR_MODE 8'he8
`define IMS_ADDR_TADDR 8'he9
`define IMS_ADDR_STAT 8'hea

// ==========================================================================
// reset value shared by every register except the rx buffer
`define IMS_RST_BYTE 8'h00

// ==========================================================================
// serial_status_reg field positions
`define IMS_ST_BUSY 7
`define IMS_ST_NOACK 6
`define IMS_ST_RXP 5
`define IMS_ST_TXE 4
`define IMS_ST_LVL_HI 3
`define IMS_ST_LVL_LO 2
`define IMS_ST_ACC 1
`define IMS_ST_OVF 0

// ==========================================================================
// fifo_level_field encodings
`define IMS_LVL_EMPTY 2'h0
`define IMS_LVL_HALF 2'h2
`define IMS_LVL_FULL 2'h3

// ==========================================================================
// mode register field positions
`define IMS_MD_EN 7
`define IMS_MD_RATE_HI 6
`define IMS_MD_RATE_LO 5
`define IMS_MD_RCT_HI 4

// ==========================================================================
// target_address_reg: direction_bit position
`define IMS_TA_DIR 0

// ==========================================================================
// timing: core clocks per quarter bit at the fastest rate (core/16 per bit)
`define IMS_QTR_BASE 6'h04

// fifo depth in bytes
`define IMS_FIFO_DEPTH 4

`endif

// File: logic/ims_fifo.v
`timescale 1ns/1ps
`include "ims_regs.vh"

// ==========================================================================
// byte fifo with flush, head word visible without a pop
module ims_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `IMS_FIFO_DEPTH,
  parameter AW = 2
) (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire flush_i,
  input wire push_i,
  input wire [WIDTH-1:0] wdata_i,
  input wire pop_i,
  output wire [WIDTH-1:0] head_o,
  output wire [AW:0] count_o,
  output wire full_o,
  output wire empty_o
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire do_push;
  wire do_pop;

  // a push into a full fifo and a pop from an empty one are dropped
  assign full_o = (cnt_r == DEPTH[AW:0]);
  assign empty_o = (cnt_r == {(AW+1){1'b0}});
  assign do_push = push_i & ~full_o;
  assign do_pop = pop_i & ~empty_o;
  assign head_o = mem_r[rp_r];
  assign count_o = cnt_r;

  // storage array, no reset needed
  always @(posedge ref_clk_i)
  begin
    if (do_push)
    begin
      mem_r[wp_r] <= wdata_i;
    end
  end

  // pointers and occupancy; flush wins over push and pop
  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else if (flush_i)
    begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
        wp_r <= wp_r + 1'b1;
      if (do_pop)
        rp_r <= rp_r + 1'b1;
      if (do_push & ~do_pop)
        cnt_r <= cnt_r + 1'b1;
      else if (do_pop & ~do_push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule // ims_fifo

// File: logic/ims_tick_gen.v
`timescale 1ns/1ps
`include "ims_regs.vh"

// ==========================================================================
// quarter-bit tick: every (base << rate) core clocks while running
module ims_tick_gen (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire run_i,
  input wire [1:0] rate_i,
  output reg tick_o
);

  reg [5:0] cnt_r;
  wire [5:0] last;

  assign last = (`IMS_QTR_BASE << rate_i) - 6'h01;

  // free count restarted whenever the engine is idle
  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_r <= 6'h00;
      tick_o <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt_r <= 6'h00;
      tick_o <= 1'b0;
    end
    else if (cnt_r >= last)
    begin
      cnt_r <= 6'h00;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 6'h01;
      tick_o <= 1'b0;
    end
  end

endmodule // ims_tick_gen

// File: tb/ims_props.sv
`timescale 1ns/1ps
`include "ims_regs.vh"

// ==========================================================================
// port-level checker for the two-wire master
module ims_props (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_rdata_o,
  input wire irq_o,
  input wire scl_i,
  input wire scl_o,
  input wire scl_oe_n_o,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_n_o
);
  reg en_r;
  wire st_rd = sfr_rd_i && !sfr_wr_i && sfr_addr_i == `IMS_ADDR_STAT;
  wire st_wr = sfr_wr_i && !sfr_rd_i && sfr_addr_i == `IMS_ADDR_STAT;
  wire md_wr = sfr_wr_i && !sfr_rd_i && sfr_addr_i == `IMS_ADDR_MODE;
  wire md_rd = sfr_rd_i && !sfr_wr_i && sfr_addr_i == `IMS_ADDR_MODE;

  // ==========================================================================
  // interface enable as last written to the mode register
  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      en_r <= 1'b0;
    else if (sfr_wr_i && sfr_addr_i == `IMS_ADDR_MODE)
      en_r <= sfr_wdata_i[`IMS_MD_EN];
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ==========================================================================
  // sequences: gap then status read, keep-all write
  sequence s_gap_rd;
    !sfr_wr_i ##1 st_rd;
  endsequence
  sequence s_keep_wr;
    st_wr && sfr_wdata_i == 8'hff;
  endsequence

  // ==========================================================================
  // assertions
  a_dead_read: assert property (sfr_rd_i && sfr_addr_i != `IMS_ADDR_RXBUF &&
    sfr_addr_i != `IMS_ADDR_MODE && sfr_addr_i != `IMS_ADDR_TADDR &&
    sfr_addr_i != `IMS_ADDR_STAT |=> sfr_rdata_o == 8'h00)
    else $error("unreadable address returned data");
  a_level_legal: assert property (st_rd |=> sfr_rdata_o[3:2] != 2'b01)
    else $error("fifo level shows the reserved code");
  a_collide_set: assert property ((sfr_wr_i && sfr_rd_i) ##1 s_gap_rd |=> sfr_rdata_o[1])
    else $error("collision flag missing");
  a_zero_clears: assert property ((st_wr && sfr_wdata_i == 8'h00) ##1 s_gap_rd
    |=> sfr_rdata_o[1:0] == 2'b00)
    else $error("zero write left an error flag");
  a_ones_keep: assert property (st_rd ##1 !sfr_wr_i ##1 s_keep_wr ##1 s_gap_rd
    |=> ($past(sfr_rdata_o, 4) & ~sfr_rdata_o & 8'h73) == 8'h00)
    else $error("writing one cleared a flag");
  a_mode_back: assert property (md_wr ##1 !sfr_wr_i ##1 md_rd
    |=> sfr_rdata_o == $past(sfr_wdata_i, 3))
    else $error("mode register read back wrong");
  a_drive_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("open-drain data output not low");
  a_quiet_off: assert property (!en_r && scl_oe_n_o && sda_oe_n_o |=>
    scl_oe_n_o && sda_oe_n_o)
    else $error("bus driven while interface disabled");
endmodule // ims_props

bind ims_master ims_props u_props (.ref_clk_i, .nrst_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i,
  .sfr_rd_i, .sfr_rdata_o, .irq_o, .scl_i, .scl_o, .scl_oe_n_o, .sda_i, .sda_o, .sda_oe_n_o);

// File: tb/ims_slave.sv
`timescale 1ns/1ps

// ==========================================================================
// two-wire slave model
module ims_slave #(
  parameter ADDR = 7'h2a
) (
  input wire clk_i,
  input wire scl_i,
  input wire sda_i,
  input wire nack_i,
  input wire stretch_i,
  input wire [7:0] base_i,
  output reg sda_rel_o,
  output reg scl_rel_o,
  output reg wr_stb_o,
  output reg [7:0] wr_byte_o,
  output integer starts_o,
  output integer stops_o,
  output integer macks_o,
  output integer mnacks_o
);
  reg scl_q = 1'b1;
  reg sda_q = 1'b1;
  reg [1:0] ph = 2'd3;
  reg [1:0] aph = 2'd3;
  reg [3:0] bitn = 4'd0;
  reg [7:0] sh = 8'h00;
  reg [7:0] tx = 8'h00;
  integer k = 0;
  integer hold = 0;

  // ==========================================================================
  // released lines, cleared counters
  initial
  begin
    sda_rel_o = 1'b1;
    scl_rel_o = 1'b1;
    wr_stb_o = 1'b0;
    wr_byte_o = 8'h00;
    starts_o = 0;
    stops_o = 0;
    macks_o = 0;
    mnacks_o = 0;
  end

  // ==========================================================================
  // oversampled bus follower; phase 0 address, 1 write, 2 read, 3 ignore
  always @(posedge clk_i)
  begin
    wr_stb_o <= 1'b0;
    if (scl_q && scl_i && sda_q && !sda_i)
    begin
      starts_o <= starts_o + 1;
      ph = 2'd0;
      bitn = 4'd0;
      k = 0;
      sda_rel_o <= 1'b1;
    end
    else if (scl_q && scl_i && !sda_q && sda_i)
    begin
      stops_o <= stops_o + 1;
      ph = 2'd3;
    end
    else if (!scl_q && scl_i && ph != 2'd3)
    begin
      if (bitn < 4'd8)
        sh = {sh[6:0], sda_i};
      else if (aph == 2'd2 && sda_i)
        mnacks_o <= mnacks_o + 1;
      else if (aph == 2'd2)
        macks_o <= macks_o + 1;
      if (bitn == 4'd8 && aph == 2'd2 && sda_i)
        ph = 2'd3;
      bitn = bitn + 4'd1;
    end
    else if (scl_q && !scl_i && ph != 2'd3)
    begin
      if (stretch_i)
        hold = 40;
      if (bitn == 4'd8)
      begin
        aph = ph;
        if (ph == 2'd0)
          ph = (sh[7:1] != ADDR || nack_i) ? 2'd3 : (sh[0] ? 2'd2 : 2'd1);
        if (ph == 2'd1 && aph == 2'd1)
        begin
          wr_byte_o <= sh;
          wr_stb_o <= 1'b1;
        end
        sda_rel_o <= (ph == 2'd3) || (aph == 2'd2);
      end
      else if (bitn == 4'd9)
      begin
        bitn = 4'd0;
        tx = base_i + k[7:0];
        k = k + 1;
        sda_rel_o <= (ph == 2'd2) ? tx[7] : 1'b1;
      end
      else if (ph == 2'd2)
        sda_rel_o <= tx[4'd7 - bitn];
    end
    if (hold > 0)
      hold = hold - 1;
    scl_rel_o <= (hold == 0);
    scl_q = scl_i;
    sda_q = sda_i;
  end
endmodule // ims_slave

// File: tb/ims_master_bench.sv
`timescale 1ns/1ps
`include "ims_regs.vh"

// ==========================================================================
// self-checking bench: register traffic against a model slave
module ims_master_bench;
  localparam [6:0] SLV = 7'h2a;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg rd_q = 1'b0;
  reg nack = 1'b0;
  reg stretch = 1'b0;
  reg [7:0] base = 8'h00;
  reg [7:0] last = 8'h00;
  reg [15:0] ent;
  reg [15:0] exp_q [$];
  reg [7:0] byte_q [$];
  reg [7:0] adrs [0:4] = '{8'he8, 8'he9, 8'hea, 8'h9a, 8'he7};
  wire [7:0] rdata;
  wire [7:0] wbyte;
  wire irq, scl_o, scl_oe_n, sda_o, sda_oe_n, scl_rel, sda_rel, wstb;
  integer starts, stops, macks, mnacks, i, polls, rnd;
  integer errors = 0;
  integer tests_run = 0;
  integer seed = 32'h01d1;
  // open-drain wires with pull-ups
  wire scl_w = (scl_oe_n ? 1'b1 : scl_o) & scl_rel;
  wire sda_w = (sda_oe_n ? 1'b1 : sda_o) & sda_rel;

  ims_master dut (.ref_clk_i(clk), .nrst_i(nrst), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .irq_o(irq), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n));
  ims_slave #(.ADDR(SLV)) u_slave (.clk_i(clk), .scl_i(scl_w), .sda_i(sda_w), .nack_i(nack),
    .stretch_i(stretch), .base_i(base), .sda_rel_o(sda_rel), .scl_rel_o(scl_rel),
    .wr_stb_o(wstb), .wr_byte_o(wbyte), .starts_o(starts), .stops_o(stops), .macks_o(macks),
    .mnacks_o(mnacks));

  always #5 clk = ~clk;

  // ==========================================================================
  // compare and count
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  // one register access; a read notes {mask, value}, mask zero means poll only
  task acc(input [7:0] a, input [7:0] d, input w, input r, input [7:0] m, input [7:0] e);
  begin
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = w;
    rd = r;
    if (r)
      exp_q.push_back({m, e});
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    last = rdata;
  end
  endtask

  task rs(input [7:0] m, input [7:0] e);
    acc(`IMS_ADDR_STAT, 8'h00, 1'b0, 1'b1, m, e);
  endtask

  task wrr(input [7:0] a, input [7:0] d);
    acc(a, d, 1'b1, 1'b0, 8'h00, 8'h00);
  endtask

  // poll status until the transfer-active flag drops, bounded
  task idle;
  begin
    polls = 0;
    last = 8'h80;
    while (last[7] === 1'b1 && polls < 4000)
    begin
      rs(8'h00, 8'h00);
      polls = polls + 1;
    end
    check("transfer ended", last[7], 1'b0);
  end
  endtask

  task test_done;
  begin
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  // ==========================================================================
  // monitor: read data the cycle after the strobe, bytes seen by the slave
  always @(posedge clk)
  begin
    if (rd_q && exp_q.size() > 0)
    begin
      ent = exp_q.pop_front();
      if (ent[15:8] != 8'h00)
        check("register read", rdata & ent[15:8], ent[7:0]);
    end
    if (wstb)
      check("slave byte", wbyte, byte_q.pop_front());
    rd_q <= rd;
  end

  // ==========================================================================
  // watchdog well past the expected run
  initial
  begin
    #400000;
    errors = errors + 1;
    test_done;
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    for (i = 0; i < 5; i = i + 1)
      acc(adrs[i], 8'h00, 1'b0, 1'b1, 8'hff, `IMS_RST_BYTE);
    check("irq after reset", irq, 1'b0);
    $display("reset test done");
    acc(8'he7, 8'h55, 1'b1, 1'b1, 8'hff, 8'h00);
    rs(8'h02, 8'h02);
    check("irq on collision", irq, 1'b1);
    wrr(`IMS_ADDR_STAT, 8'hff);
    rs(8'h02, 8'h02);
    wrr(`IMS_ADDR_STAT, 8'h00);
    rs(8'h02, 8'h00);
    $display("collision test done");
    wrr(`IMS_ADDR_MODE, 8'he0);
    acc(`IMS_ADDR_MODE, 8'h00, 1'b0, 1'b1, 8'hff, 8'he0);
    wrr(`IMS_ADDR_TADDR, {SLV, 1'b0});
    rs(8'h8c, 8'h80);
    for (i = 0; i < 5; i = i + 1)
    begin
      rnd = $random(seed);
      if (i < 4)
        byte_q.push_back(rnd[7:0]);
      wrr(`IMS_ADDR_TXBUF, rnd[7:0]);
    end
    rs(8'h0d, 8'h0d);
    idle;
    rs(8'h1d, 8'h11);
    wrr(`IMS_ADDR_STAT, 8'h00);
    rs(8'hf3, 8'h00);
    check("bytes not delivered", byte_q.size(), 0);
    check("bus released", {scl_w, sda_w}, 2'b11);
    $display("write test done");
    stretch = 1'b1;
    rnd = $random(seed);
    base = rnd[7:0];
    wrr(`IMS_ADDR_MODE, 8'h83);
    wrr(`IMS_ADDR_TADDR, {SLV, 1'b1});
    idle;
    check("master acks", macks, 3);
    check("master nacks", mnacks, 1);
    rs(8'h2c, 8'h2c);
    for (i = 0; i < 4; i = i + 1)
      acc(`IMS_ADDR_RXBUF, 8'h00, 1'b0, 1'b1, 8'hff, base + i[7:0]);
    rs(8'h2c, 8'h20);
    wrr(`IMS_ADDR_STAT, 8'h00);
    rs(8'h20, 8'h00);
    $display("read test done");
    stretch = 1'b0;
    nack = 1'b1;
    wrr(`IMS_ADDR_MODE, 8'h80);
    wrr(`IMS_ADDR_TADDR, {SLV, 1'b0});
    idle;
    nack = 1'b0;
    wrr(`IMS_ADDR_STAT, 8'hff);
    rs(8'h40, 8'h40);
    check("irq on no-ack", irq, 1'b1);
    wrr(`IMS_ADDR_STAT, 8'h00);
    rs(8'h40, 8'h00);
    check("irq cleared", irq, 1'b0);
    $display("no-ack test done");
    wrr(`IMS_ADDR_TADDR, {SLV, 1'b1});
    wrr(`IMS_ADDR_TADDR, {SLV, 1'b1});
    idle;
    check("starts", starts, 5);
    check("stops", stops, 4);
    check("master nacks", mnacks, 3);
    acc(`IMS_ADDR_RXBUF, 8'h00, 1'b0, 1'b1, 8'hff, base);
    acc(`IMS_ADDR_RXBUF, 8'h00, 1'b0, 1'b1, 8'hff, base);
    $display("restart test done");
    wrr(`IMS_ADDR_MODE, 8'h00);
    wrr(`IMS_ADDR_TADDR, {SLV, 1'b0});
    rs(8'h80, 8'h00);
    check("starts when disabled", starts, 5);
    $display("disable test done");
    test_done;
  end
endmodule // ims_master_bench
